// ===== hdl/rxq_pkg.sv
// Register indices, reset values and field widths of the receive queue
// register block.
// Assumes the byte address of a register is four times its index.
package rxq_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MAX_LEN = 8'hb6;
  localparam logic [7:0] IDX_MIN_LEN = 8'hb7;
  localparam logic [7:0] IDX_LO_FC = 8'hb8;
  localparam logic [7:0] IDX_HI_FC = 8'hb9;
  localparam logic [7:0] IDX_LO_HW = 8'hba;
  localparam logic [7:0] IDX_HI_HW = 8'hbb;
  localparam logic [7:0] IDX_P2P_HW = 8'hbc;
  localparam logic [7:0] IDX_HEAD_SIZE = 8'hc0;
  localparam logic [7:0] IDX_RX_DATA = 8'hc1;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MAX_LEN_RST = 16'h0618;
  localparam logic [15:0] MIN_LEN_RST = 16'h0040;
  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int LEN_W = 16;
  localparam int FC_W = 9;
  localparam int HW_W = 14;
  localparam int FS_W = 11;
endpackage

// ===== hdl/rxq_regs.sv
// Receive frame bounds, queue status registers and the host read path
// of the second port's receive queue.
// Assumes all inputs come from logic on sys_clk; the serial host port
// decoder in front turns each register access into one strobe.
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Flip-flop FIFO; D must be a power of two and at least 2
// ------------------------------------------------------------------
module rxq_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic push,
  input wire logic [W-1:0] din,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign empty = (wp == rp);
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign dout = mem[rp[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (do_push) wp <= wp + 1'b1;
      if (do_pop) rp <= rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_push) mem[wp[AW-1:0]] <= din;
  end
endmodule // rxq_fifo

// Functional notes
// R1 - Read/write max length, reset 0x618
// R2 - Read/write min length, reset 0x40
// R3 - Out-of-bounds lengths counted as length errors
// R4 - Read-only low queue frame count
// R5 - Read-only high queue frame count
// R6 - Host may rely on frame-waiting flag only
// R7 - Read-only low queue half-word level
// R8 - Read-only high queue half-word level
// R9 - Read-only port-to-port transmit half-word level
// R10 - Head frame size including header bytes
// R11 - Host reads size before pulling frame data
// R12 - Size and data only in generic mode
// R13 - Data read returns and pops four bytes
// R14 - Earliest byte in most significant lane
// R15 - After frame end, data blocked until size read
// R16 - Consecutive words in one burst
module rxq_regs #(
  parameter int WDEPTH = 16,
  parameter int FDEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register access strobes
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Host port protocol select, high for the generic protocol
  input wire logic generic_spi_mode,
  // Receive length check
  input wire logic len_valid,
  input wire logic [rxq_pkg::LEN_W-1:0] len_bytes,
  output logic len_error,
  output logic [31:0] ls_err_count,
  // Queue status from the first port's queues
  input wire logic [rxq_pkg::FC_W-1:0] lo_frames,
  input wire logic [rxq_pkg::FC_W-1:0] hi_frames,
  input wire logic [rxq_pkg::HW_W-1:0] lo_halfwords,
  input wire logic [rxq_pkg::HW_W-1:0] hi_halfwords,
  input wire logic [rxq_pkg::HW_W-1:0] p2p_halfwords,
  // Second port receive queue fill side
  input wire logic q_valid,
  output logic q_ready,
  input wire logic [31:0] q_data,
  input wire logic q_last,
  input wire logic [rxq_pkg::FS_W-1:0] q_size,
  // At least one whole frame waits
  output logic rx_frame_waiting_flag
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [rxq_pkg::LEN_W-1:0] max_len_field;
  logic [rxq_pkg::LEN_W-1:0] min_len_field;
  logic frame_open;
  wire [7:0] idx = reg_addr[9:2];
  // A misaligned access is dropped whole rather than rounded down, so a
  // decoder fault can never pop the queue by accident.
  wire aligned = (reg_addr[1:0] == 2'b00);
  wire rd_ok = reg_rd && aligned;
  wire wr_ok = reg_wr && aligned;
  wire hit_max = (idx == rxq_pkg::IDX_MAX_LEN);
  wire hit_min = (idx == rxq_pkg::IDX_MIN_LEN);
  wire hit_lfc = (idx == rxq_pkg::IDX_LO_FC);
  wire hit_hfc = (idx == rxq_pkg::IDX_HI_FC);
  wire hit_lhw = (idx == rxq_pkg::IDX_LO_HW);
  wire hit_hhw = (idx == rxq_pkg::IDX_HI_HW);
  wire hit_p2p = (idx == rxq_pkg::IDX_P2P_HW);
  wire hit_fs = (idx == rxq_pkg::IDX_HEAD_SIZE);
  wire hit_rx = (idx == rxq_pkg::IDX_RX_DATA);

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  // Sizes sit in their own FIFO so the head size is known as soon as a
  // frame is complete, without walking the word store.
  wire [32:0] wq_out;
  wire wq_empty;
  wire wq_full;
  wire [rxq_pkg::FS_W-1:0] sq_out;
  wire sq_empty;
  wire sq_full;
  wire q_push = q_valid && q_ready;
  wire wq_last = wq_out[32];
  wire rd_size = rd_ok && hit_fs && generic_spi_mode; // [R12]
  wire rd_data = rd_ok && hit_rx && generic_spi_mode; // [R12]
  wire word_pop = rd_data && frame_open && !wq_empty; // [R13] [R15] [R16]
  wire size_pop = word_pop && wq_last;
  wire [rxq_pkg::FS_W-1:0] head_size = sq_empty ? '0 : sq_out; // [R10]

  // Ready waits on both stores, so a last word is never taken without
  // room for its size; otherwise a frame could lose its length.
  assign q_ready = !wq_full && !sq_full;
  assign rx_frame_waiting_flag = !sq_empty;

  rxq_fifo #(.W(33), .D(WDEPTH)) u_words (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(q_push),
    .din({q_last, q_data}),
    .pop(word_pop),
    .dout(wq_out),
    .empty(wq_empty),
    .full(wq_full)
  );

  rxq_fifo #(.W(rxq_pkg::FS_W), .D(FDEPTH)) u_sizes (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(q_push && q_last),
    .din(q_size),
    .pop(size_pop),
    .dout(sq_out),
    .empty(sq_empty),
    .full(sq_full)
  );

  // Reading the size arms data reads; the last word of a frame closes
  // them again, so a host cannot run into the next frame unknowingly.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_open <= 1'b0;
    end else if (size_pop) begin
      frame_open <= 1'b0; // [R15]
    end else if (rd_size && !sq_empty) begin
      frame_open <= 1'b1; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Length bounds
  // ----------------------------------------------------------------
  // Both bounds themselves are accepted lengths.
  wire len_bad = len_valid && ((len_bytes > max_len_field) ||
                               (len_bytes < min_len_field));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      max_len_field <= rxq_pkg::MAX_LEN_RST; // [R1]
      min_len_field <= rxq_pkg::MIN_LEN_RST; // [R2]
    end else if (wr_ok) begin
      if (hit_max) max_len_field <= reg_wdata[15:0]; // [R1]
      if (hit_min) min_len_field <= reg_wdata[15:0]; // [R2]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      len_error <= 1'b0;
      ls_err_count <= 32'h0000_0000;
    end else begin
      len_error <= len_bad; // [R3]
      if (len_bad) ls_err_count <= ls_err_count + 32'h0000_0001; // [R3]
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Upper bits of every narrow field read as zero; so do unmapped
  // addresses and the queue registers outside the generic protocol.
  wire [31:0] data_word = word_pop ? wq_out[31:0] : 32'h0000_0000; // [R13] [R14]
  wire [31:0] size_word = generic_spi_mode ? {21'h00_0000, head_size} : 32'h0000_0000;
  // Priority order does not matter: at most one hit is ever true.
  wire [31:0] rd_mux =
    hit_max ? {16'h0000, max_len_field} :
    hit_min ? {16'h0000, min_len_field} :
    hit_lfc ? {23'h00_0000, lo_frames} : // [R4]
    hit_hfc ? {23'h00_0000, hi_frames} : // [R5]
    hit_lhw ? {18'h0_0000, lo_halfwords} : // [R7]
    hit_hhw ? {18'h0_0000, hi_halfwords} : // [R8]
    hit_p2p ? {18'h0_0000, p2p_halfwords} : // [R9]
    hit_fs ? size_word :
    hit_rx ? data_word : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_ok;
      // Read data is taken only on a taken read and holds otherwise.
      if (rd_ok) reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_max_reset: assert property ($past(rst) |-> max_len_field == rxq_pkg::MAX_LEN_RST) // [R1]
    else $error("max length reset value wrong");
  chk_min_reset: assert property ($past(rst) |-> min_len_field == rxq_pkg::MIN_LEN_RST) // [R2]
    else $error("min length reset value wrong");
  chk_max_write: assert property (wr_ok && hit_max ##1 rd_ok && hit_max |=> // [R1]
    reg_rdata == {16'h0000, $past(reg_wdata[15:0], 2)})
    else $error("max length write not read back");
  chk_len_error: assert property (len_bad |=> len_error && // [R3]
    ls_err_count == $past(ls_err_count) + 32'h0000_0001)
    else $error("length error not counted");
  chk_len_good: assert property (len_valid && !len_bad |=> !len_error) // [R3]
    else $error("good length flagged");
  chk_lo_count: assert property (rd_ok && hit_lfc |=> reg_rvalid && // [R4]
    reg_rdata == {23'h00_0000, $past(lo_frames)})
    else $error("low frame count read wrong");
  chk_hi_count: assert property (rd_ok && hit_hfc |=> // [R5]
    reg_rdata == {23'h00_0000, $past(hi_frames)})
    else $error("high frame count read wrong");
  chk_lo_level: assert property (rd_ok && hit_lhw |=> // [R7]
    reg_rdata == {18'h0_0000, $past(lo_halfwords)})
    else $error("low level read wrong");
  chk_hi_level: assert property (rd_ok && hit_hhw |=> // [R8]
    reg_rdata == {18'h0_0000, $past(hi_halfwords)})
    else $error("high level read wrong");
  chk_p2p_level: assert property (rd_ok && hit_p2p |=> // [R9]
    reg_rdata == {18'h0_0000, $past(p2p_halfwords)})
    else $error("port-to-port level read wrong");
  chk_size_read: assert property (rd_size |=> // [R10]
    reg_rdata == {21'h00_0000, $past(head_size)})
    else $error("head size read wrong");
  chk_mode_gate: assert property (rd_ok && (hit_fs || hit_rx) && !generic_spi_mode // [R12]
    |=> reg_rdata == 32'h0000_0000 && $stable(frame_open))
    else $error("queue read outside generic mode");
  chk_pop_word: assert property (word_pop |=> // [R13] [R14]
    reg_rdata == $past(wq_out[31:0]))
    else $error("popped word wrong");
  chk_frame_close: assert property (size_pop |=> !frame_open) // [R15]
    else $error("data reads not closed after frame end");
  chk_burst_next: assert property (word_pop && !wq_last ##1 rd_data && !wq_empty // [R16]
    |-> word_pop)
    else $error("burst word not supplied");

  // ----------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------
  // Read data holds between reads, so a slow serial decoder may take it
  // at any later cycle; the cost is one 32-bit holding register.
  chk_min_write: assert property (wr_ok && hit_min ##1 rd_ok && hit_min |=> // [R2]
    reg_rdata == {16'h0000, $past(reg_wdata[15:0], 2)})
    else $error("min length write not read back");
  chk_reserved_zero: assert property (rd_ok && (hit_max || hit_min) |=> // [R1] [R2]
    reg_rdata[31:16] == 16'h0000)
    else $error("reserved length bits not zero");
  chk_max_hold: assert property (!(wr_ok && hit_max) |=> $stable(max_len_field)) // [R1]
    else $error("max length changed without write");
  chk_min_hold: assert property (!(wr_ok && hit_min) |=> $stable(min_len_field)) // [R2]
    else $error("min length changed without write");
  chk_rvalid_pulse: assert property (rd_ok |=> reg_rvalid) // [R13]
    else $error("read not answered");
  chk_rvalid_idle: assert property (!rd_ok |=> !reg_rvalid) // [R13]
    else $error("answer without read");
  chk_rdata_hold: assert property (!rd_ok |=> $stable(reg_rdata)) // [R13]
    else $error("read data changed without read");

  // ----------------------------------------------------------------
  // Length counter checks
  // ----------------------------------------------------------------
  chk_count_hold: assert property (!len_bad |=> $stable(ls_err_count)) // [R3]
    else $error("error count moved on good length");
  chk_len_idle: assert property (!len_valid |=> !len_error) // [R3]
    else $error("length error without length");

  // ----------------------------------------------------------------
  // Frame gating checks
  // ----------------------------------------------------------------
  // A closed or empty queue answers zero and keeps its words, so a stray
  // read can never skip data of the next frame.
  chk_closed_zero: assert property (rd_data && !frame_open |=> // [R15]
    reg_rdata == 32'h0000_0000)
    else $error("data returned while closed");
  chk_pop_empty: assert property (rd_data && wq_empty |=> // [R13]
    reg_rdata == 32'h0000_0000)
    else $error("data returned from empty queue");
  chk_size_arm: assert property (rd_size && !sq_empty |=> frame_open) // [R15]
    else $error("size read did not arm data");
  chk_size_noarm: assert property (rd_size && sq_empty && !frame_open |=> !frame_open) // [R15]
    else $error("size read armed an empty queue");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  // Main scenarios: a whole frame, a burst, a length error, a full queue
  // and a data read outside the generic protocol.
  cov_frame_done: cover property (size_pop);
  cov_burst: cover property (word_pop ##1 word_pop ##1 word_pop);
  cov_len_err: cover property (len_error);
  cov_backpressure: cover property (q_valid && !q_ready);
  cov_mode_off: cover property (rd_ok && hit_rx && !generic_spi_mode);
endmodule // rxq_regs

// ===== verification/rxq_src_model.sv
// Frame source model on the fill side of the second port receive queue.
// Assumes the bench fills wq before calling send, between edges.
`timescale 1ns/1ns
module rxq_src_model (
  // Clock
  input wire logic sys_clk,
  // Queue fill side
  output logic q_valid,
  input wire logic q_ready,
  output logic [31:0] q_data,
  output logic q_last,
  output logic [10:0] q_size,
  // Wait bound exhausted
  output logic hung
);
  logic [31:0] wq[$];
  logic rdy;
  initial begin
    q_valid = 1'b0;
    q_data = 32'h0000_0000;
    q_last = 1'b0;
    q_size = 11'h000;
    hung = 1'b0;
  end
  task automatic send(input logic [10:0] sz);
    while (wq.size() > 0) begin
      q_valid = 1'b1;
      q_data = wq[0];
      q_last = (wq.size() == 1);
      q_size = q_last ? sz : ~sz;
      for (int n = 0; n < 50; n++) begin
        rdy = q_ready;
        @(posedge sys_clk);
        #1;
        if (rdy) begin
          break;
        end
        if (n == 49) hung = 1'b1;
      end
      void'(wq.pop_front());
    end
    // A released bus shows the inverse so stale data never looks valid.
    q_valid = 1'b0;
    q_data = ~q_data;
    q_last = 1'b0;
  endtask
endmodule // rxq_src_model

// ===== verification/testbench.sv
// Self-checking bench of the receive queue register block.
// Assumes the frame source model drives the fill side of the queue.
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic generic_spi_mode = 1'b1;
  logic len_valid = 1'b0;
  logic [15:0] len_bytes = 16'h0000;
  logic len_error;
  logic [31:0] ls_err_count;
  logic [8:0] st_fc[2] = '{9'h000, 9'h000};
  logic [13:0] st_hw[3] = '{14'h0000, 14'h0000, 14'h0000};
  logic q_valid, q_ready, q_last, flag, hung;
  logic [31:0] q_data;
  logic [10:0] q_size;
  logic [31:0] seed = 32'h0000_d66b;
  logic [31:0] v, e;
  logic [15:0] ln;
  logic [31:0] mq[$];
  int err_count = 0;
  int checks_done = 0;
  int errs = 0;
  always #5 sys_clk = ~sys_clk;
  rxq_regs dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .generic_spi_mode(generic_spi_mode), .len_valid(len_valid), .len_bytes(len_bytes),
    .len_error(len_error), .ls_err_count(ls_err_count), .lo_frames(st_fc[0]),
    .hi_frames(st_fc[1]), .lo_halfwords(st_hw[0]), .hi_halfwords(st_hw[1]),
    .p2p_halfwords(st_hw[2]), .q_valid(q_valid), .q_ready(q_ready), .q_data(q_data),
    .q_last(q_last), .q_size(q_size), .rx_frame_waiting_flag(flag));
  rxq_src_model src_u (.sys_clk(sys_clk), .q_valid(q_valid), .q_ready(q_ready),
    .q_data(q_data), .q_last(q_last), .q_size(q_size), .hung(hung));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    reg_addr = {idx, 2'b00};
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    reg_addr = {idx, 2'b00};
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    chk({reg_rvalid, reg_rdata[30:0]}, {1'b1, exp[30:0]});
    chk(reg_rdata, exp);
    @(posedge sys_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    err_count++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rdc(rxq_pkg::IDX_MAX_LEN, 32'h0000_0618);
    rdc(rxq_pkg::IDX_MIN_LEN, 32'h0000_0040);
    rdc(rxq_pkg::IDX_HEAD_SIZE, 32'h0000_0000);
    rdc(rxq_pkg::IDX_RX_DATA, 32'h0000_0000);
    rdc(8'hc4, 32'h0000_0000);
    v = xs();
    wr(rxq_pkg::IDX_MAX_LEN, {v[31:16], 16'h0200});
    rdc(rxq_pkg::IDX_MAX_LEN, 32'h0000_0200);
    wr(rxq_pkg::IDX_MIN_LEN, {v[15:0], 16'h0020});
    rdc(rxq_pkg::IDX_MIN_LEN, 32'h0000_0020);
    $display("test bounds done");
    // Both edges of each bound, then random lengths.
    len_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = xs();
      ln = (i == 0) ? 16'h001f : (i == 1) ? 16'h0020 : (i == 2) ? 16'h0200 : v[15:0];
      ln = (i == 3) ? 16'h0201 : ln;
      len_bytes = ln;
      @(posedge sys_clk);
      #1;
      e = 32'(ln > 16'h0200 || ln < 16'h0020);
      errs += int'(e);
      chk(32'(len_error), e);
      chk(ls_err_count, 32'(errs));
    end
    len_valid = 1'b0;
    len_bytes = ~ln;
    $display("test length check done");
    for (int i = 0; i < 5; i++) begin
      v = xs();
      st_fc[0] = v[8:0];
      st_fc[1] = v[17:9];
      st_hw[0] = v[13:0];
      st_hw[1] = v[27:14];
      st_hw[2] = v[31:18];
      wr(rxq_pkg::IDX_LO_FC + 8'(i), ~v);
      e = (i < 2) ? 32'(st_fc[i]) : 32'(st_hw[i - 2]);
      rdc(rxq_pkg::IDX_LO_FC + 8'(i), e);
    end
    $display("test status done");
    for (int i = 0; i < 3; i++) begin
      v = xs();
      src_u.wq.push_back(v);
      mq.push_back(v);
    end
    src_u.send(11'd10);
    chk(32'(flag), 32'h1);
    generic_spi_mode = 1'b0;
    rdc(rxq_pkg::IDX_HEAD_SIZE, 32'h0000_0000);
    rdc(rxq_pkg::IDX_RX_DATA, 32'h0000_0000);
    generic_spi_mode = 1'b1;
    rdc(rxq_pkg::IDX_HEAD_SIZE, 32'h0000_000a);
    reg_addr = {rxq_pkg::IDX_RX_DATA, 2'b00};
    reg_rd = 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      #1;
      reg_rd = (i < 2);
      chk(reg_rdata, mq.pop_front());
    end
    chk(32'(flag), 32'h0);
    v = xs();
    src_u.wq.push_back(v);
    src_u.send(11'd4);
    // A waiting frame stays unread until its size has been asked for.
    rdc(rxq_pkg::IDX_RX_DATA, 32'h0000_0000);
    rdc(rxq_pkg::IDX_HEAD_SIZE, 32'h0000_0004);
    rdc(rxq_pkg::IDX_RX_DATA, v);
    chk(32'(hung), 32'h0);
    $display("test frame read done");
    give_verdict();
  end
endmodule // testbench
